/* File: design/led_indicator_control_map.svh */
// Purpose: offsets, field positions, reset values and timing figures of the LED block
// Assumes: word index of a register is its printed offset; byte address is four times it
// Notes:   definitions only
`ifndef LED_INDICATOR_CONTROL_MAP_SVH
`define LED_INDICATOR_CONTROL_MAP_SVH
// ****************************************
// register map
// ****************************************
`define SECOND_CFG_IDX 16'hA00D
`define THIRD_CFG_IDX  16'hA00E
`define BLINK_CFG_IDX  16'hA00F
`define SECOND_CFG_RST 16'h0620
`define THIRD_CFG_RST  16'h0640
`define BLINK_CFG_RST  7'h06
// ****************************************
// configuration word fields
// ****************************************
`define F_SRC_HI 15
`define F_SRC_LO 14
`define F_LAB    13
`define F_FDE    12
`define F_HDE    11
`define F_TABE   10
`define F_RABE   9
`define F_TAE    8
`define F_RAE    7
`define F_GE     6
`define F_FE     5
`define F_BE     4
`define F_CBE    3
`define F_GBE    2
`define F_FBE    1
`define F_BBE    0
`define DUTY_HI  6
`define DUTY_LO  4
`define RATE2_HI 3
`define RATE2_LO 2
`define RATE1_HI 1
`define RATE1_LO 0
// ****************************************
// status vector bits and speed codes
// ****************************************
`define ST_LINK  0
`define ST_10    1
`define ST_100   2
`define ST_1000  3
`define ST_FD    4
`define ST_TX    5
`define ST_RX    6
`define ST_COL   7
`define SPEED_10   2'h0
`define SPEED_100  2'h1
`define SPEED_1000 2'h2
// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS    100
`define SLOT_TIME_NS     5208333
`define MIN_ON_TIME_NS   10000000
`define SLOTS_PER_PERIOD 4'hC
`endif

/* File: design/led_indicator_control_pkg.sv */
// Purpose: shared types of the LED block
// Assumes: nothing
// Notes:   encodings of the source field follow its bit values
package led_indicator_control_pkg;
  typedef enum logic [1:0] {SRC_COPPER, SRC_SERIAL, SRC_AND, SRC_OR} source_sel_t;
  typedef logic [7:0] status_t;
endpackage

/* File: design/led_blink_gen.sv */
// Purpose: free-running blink generator shared by all LEDs
// Assumes: one slot tick is a twelfth of a 16 Hz period
// Notes:   each rate runs its own slot counter so duty holds at every rate
`timescale 1ns/1ps
`include "led_indicator_control_map.svh"
module led_blink_gen import led_indicator_control_pkg::*; #(
  parameter int SLOT_CYC = 52083
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [6:0] blink_cfg,
  output logic            blink_one,
  output logic            blink_two
);
  logic [16:0] pre_q;
  logic        tick;
  logic [2:0]  sub_q  [4];
  logic [3:0]  slot_q [4];
  logic [3:0]  lvl;

  // a ratio of twelfths covers every duty code exactly
  function automatic logic [3:0] on_slots(input logic [2:0] duty);
    case (duty)
      3'h1:    on_slots = 4'h8;
      3'h2:    on_slots = 4'h9;
      3'h3:    on_slots = 4'hA;
      3'h5:    on_slots = 4'h4;
      3'h6:    on_slots = 4'h3;
      3'h7:    on_slots = 4'h2;
      default: on_slots = 4'h6;
    endcase
  endfunction

  assign tick = (pre_q == 17'(SLOT_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (rst || tick) begin
      pre_q <= 17'h0;
    end else begin
      pre_q <= pre_q + 17'h1;
    end
  end

  // rate r: 2,4,8,16 Hz; a slot lasts 8>>r ticks
  always_ff @(posedge core_clk) begin
    for (int r = 0; r < 4; r++) begin
      if (rst) begin
        sub_q[r]  <= 3'h0;
        slot_q[r] <= 4'h0;
      end else if (tick) begin
        if (sub_q[r] == 3'(7 >> r)) begin
          sub_q[r]  <= 3'h0;
          slot_q[r] <= (slot_q[r] == `SLOTS_PER_PERIOD - 4'h1) ? 4'h0 : slot_q[r] + 4'h1;
        end else begin
          sub_q[r] <= sub_q[r] + 3'h1;
        end
      end
    end
  end

  always_comb begin
    for (int r = 0; r < 4; r++) begin
      lvl[r] = slot_q[r] < on_slots(blink_cfg[`DUTY_HI:`DUTY_LO]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      blink_one <= 1'b0;
      blink_two <= 1'b0;
    end else begin
      blink_one <= lvl[blink_cfg[`RATE1_HI:`RATE1_LO]];
      blink_two <= lvl[blink_cfg[`RATE2_HI:`RATE2_LO]];
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_fast_slot_wrap: assert property (tick && slot_q[3] == 4'hB |=> slot_q[3] == 4'h0)
    else $error("fast slot counter did not wrap after twelve slots");
  a_slow_slot_hold: assert property (tick && sub_q[0] != 3'h7 |=> $stable(slot_q[0]))
    else $error("slow slot advanced before eight ticks");
endmodule

/* File: design/led_channel.sv */
// Purpose: indication logic of one LED from its combined status
// Assumes: status already merged per the LED's source field
// Notes:   activity blink beats other blink, which beats minimum-on and steady on
`timescale 1ns/1ps
`include "led_indicator_control_map.svh"
module led_channel import led_indicator_control_pkg::*; #(
  parameter int MIN_ON_CYC = 100000
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [13:0] cfg,
  input  wire status_t     st,
  input  wire logic        blink_one,
  input  wire logic        blink_two,
  output logic             led_q
);
  logic        link, steady, act_blink, oth_blink, trig;
  logic [16:0] hold_q;

  assign link      = st[`ST_LINK];
  assign steady    = (cfg[`F_GE] & st[`ST_1000]) | (cfg[`F_FE] & st[`ST_100]) | (cfg[`F_BE] & st[`ST_10])
                   | (cfg[`F_FDE] & st[`ST_FD]) | (cfg[`F_HDE] & ~st[`ST_FD]);
  // with the indicator bit clear, activity blinks only an LED that is on
  assign act_blink = ((cfg[`F_TABE] & st[`ST_TX]) | (cfg[`F_RABE] & st[`ST_RX])) & (cfg[`F_LAB] | steady);
  assign oth_blink = (cfg[`F_GBE] & st[`ST_1000]) | (cfg[`F_FBE] & st[`ST_100]) | (cfg[`F_BBE] & st[`ST_10])
                   | (cfg[`F_CBE] & st[`ST_COL]);
  assign trig      = (cfg[`F_TAE] & st[`ST_TX]) | (cfg[`F_RAE] & st[`ST_RX]);

  always_ff @(posedge core_clk) begin
    if (rst || !link) begin
      hold_q <= 17'h0;
    end else if (trig) begin
      hold_q <= 17'(MIN_ON_CYC);
    end else if (hold_q != 17'h0) begin
      hold_q <= hold_q - 17'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !link) begin
      led_q <= 1'b0;
    end else if (act_blink) begin
      led_q <= blink_two;
    end else if (oth_blink) begin
      led_q <= blink_one;
    end else begin
      led_q <= steady | (hold_q != 17'h0);
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_trig;
    link && trig && !act_blink && !oth_blink;
  endsequence
  sequence s_quiet;
    link && !act_blink && !oth_blink;
  endsequence

  a_dark_link_down: assert property (!link |=> !led_q)
    else $error("LED lit while link down");
  a_act_blink_rate: assert property (link && act_blink |=> led_q == $past(blink_two))
    else $error("activity blink not at second rate");
  a_steady_on_lit: assert property (link && steady && !act_blink && !oth_blink |=> led_q)
    else $error("steady condition did not light LED");
  a_min_on_hold: assert property (s_trig ##1 s_quiet[*2] |=> led_q)
    else $error("LED dropped inside minimum on time");
endmodule

/* File: design/led_indicator_control.sv */
// Purpose: second and third status LED control with register access over Wishbone
// Assumes: status inputs come from core logic on core_clk; strap pin is asynchronous
// Notes:   registers sit at byte address four times their word index
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "led_indicator_control_map.svh"
module led_indicator_control import led_indicator_control_pkg::*; #(
  parameter int SLOT_CYC   = `SLOT_TIME_NS / `CLK_PERIOD_NS,
  parameter int MIN_ON_CYC = `MIN_ON_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [17:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic [1:0]  strap_chip_mode,
  input  wire logic        copper_link_up,
  input  wire logic [1:0]  copper_speed,
  input  wire logic        copper_full_duplex,
  input  wire logic        copper_tx_act,
  input  wire logic        copper_rx_act,
  input  wire logic        copper_collision,
  input  wire logic        serial_link_up,
  input  wire logic [1:0]  serial_speed,
  input  wire logic        serial_full_duplex,
  input  wire logic        serial_tx_act,
  input  wire logic        serial_rx_act,
  input  wire logic        serial_collision,
  output logic             second_led,
  output logic             third_led
);
  // ****************************************
  // declarations
  // ****************************************
  logic [1:0]  strap_meta_q;
  logic [1:0]  strap_sync_q;
  logic        strap_pending_q;
  logic [15:0] second_cfg_q;
  logic [15:0] third_cfg_q;
  logic [6:0]  blink_cfg_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        req;
  logic [15:0] idx;
  logic [15:0] rd_word;
  logic [15:0] blink_merged;
  status_t     copper_st;
  status_t     serial_st;
  status_t     second_st;
  status_t     third_st;
  logic        blink_one;
  logic        blink_two;

  // ****************************************
  // functions
  // ****************************************
  function automatic source_sel_t mode_to_source(input logic [1:0] mode);
    case (mode)
      2'h1:    mode_to_source = SRC_SERIAL;
      2'h2:    mode_to_source = SRC_AND;
      2'h3:    mode_to_source = SRC_OR;
      default: mode_to_source = SRC_COPPER;
    endcase
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d, input logic [1:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic status_t pack_status(input logic link, input logic [1:0] spd, input logic fd,
                                          input logic tx, input logic rx, input logic col);
    pack_status = {col, rx, tx, fd, spd == `SPEED_1000, spd == `SPEED_100, spd == `SPEED_10, link};
  endfunction

  function automatic status_t combine(input logic [1:0] sel, input status_t c, input status_t s);
    case (source_sel_t'(sel))
      SRC_SERIAL: combine = s;
      SRC_AND:    combine = c & s;
      SRC_OR:     combine = c | s;
      default:    combine = c;
    endcase
  endfunction

  // ****************************************
  // strap capture
  // ****************************************
  // strap is held steady across reset, so two stages settle before release
  always_ff @(posedge core_clk) begin
    strap_meta_q <= strap_chip_mode;
    strap_sync_q <= strap_meta_q;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      strap_pending_q <= 1'b1;
    end else begin
      strap_pending_q <= 1'b0;
    end
  end

  // ****************************************
  // wishbone slave
  // ****************************************
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign idx = wb_adr_i[17:2];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      second_cfg_q <= `SECOND_CFG_RST;
    end else if (strap_pending_q) begin
      second_cfg_q[`F_SRC_HI:`F_SRC_LO] <= mode_to_source(strap_sync_q);
    end else if (req && wb_we_i && idx == `SECOND_CFG_IDX) begin
      second_cfg_q <= merge16(second_cfg_q, wb_dat_i[15:0], wb_sel_i[1:0]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      third_cfg_q <= `THIRD_CFG_RST;
    end else if (strap_pending_q) begin
      third_cfg_q[`F_SRC_HI:`F_SRC_LO] <= mode_to_source(strap_sync_q);
    end else if (req && wb_we_i && idx == `THIRD_CFG_IDX) begin
      third_cfg_q <= merge16(third_cfg_q, wb_dat_i[15:0], wb_sel_i[1:0]);
    end
  end

  assign blink_merged = merge16({9'h000, blink_cfg_q}, wb_dat_i[15:0], wb_sel_i[1:0]);

  // upper bits of the blink word are reserved and never stored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      blink_cfg_q <= `BLINK_CFG_RST;
    end else if (req && wb_we_i && idx == `BLINK_CFG_IDX) begin
      blink_cfg_q <= blink_merged[6:0];
    end
  end

  always_comb begin
    case (idx)
      `SECOND_CFG_IDX: rd_word = second_cfg_q;
      `THIRD_CFG_IDX:  rd_word = third_cfg_q;
      `BLINK_CFG_IDX:  rd_word = {9'h000, blink_cfg_q};
      default:         rd_word = 16'h0000;
    endcase
  end

  // unmapped addresses still answer, reading zero, so a stray access never hangs the bus
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dat_q <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      dat_q <= {16'h0000, rd_word};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ****************************************
  // status selection
  // ****************************************
  assign copper_st = pack_status(copper_link_up, copper_speed, copper_full_duplex,
                                 copper_tx_act, copper_rx_act, copper_collision);
  assign serial_st = pack_status(serial_link_up, serial_speed, serial_full_duplex,
                                 serial_tx_act, serial_rx_act, serial_collision);
  assign second_st = combine(second_cfg_q[`F_SRC_HI:`F_SRC_LO], copper_st, serial_st);
  assign third_st  = combine(third_cfg_q[`F_SRC_HI:`F_SRC_LO], copper_st, serial_st);

  // ****************************************
  // blink source and LED channels
  // ****************************************
  // one divider for both LEDs keeps them blinking in phase
  led_blink_gen #(
    .SLOT_CYC (SLOT_CYC)
  ) u_blink (
    .core_clk  (core_clk),
    .rst       (rst),
    .blink_cfg (blink_cfg_q),
    .blink_one (blink_one),
    .blink_two (blink_two)
  );

  led_channel #(
    .MIN_ON_CYC (MIN_ON_CYC)
  ) u_second (
    .core_clk  (core_clk),
    .rst       (rst),
    .cfg       (second_cfg_q[13:0]),
    .st        (second_st),
    .blink_one (blink_one),
    .blink_two (blink_two),
    .led_q     (second_led)
  );

  led_channel #(
    .MIN_ON_CYC (MIN_ON_CYC)
  ) u_third (
    .core_clk  (core_clk),
    .rst       (rst),
    .cfg       (third_cfg_q[13:0]),
    .st        (third_st),
    .blink_one (blink_one),
    .blink_two (blink_two),
    .led_q     (third_led)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_second_reset_word: assert property ($fell(rst) |-> second_cfg_q[13:0] == 14'h0620)
    else $error("second LED word low bits wrong after reset");
  a_third_reset_word: assert property ($fell(rst) |-> third_cfg_q[13:0] == 14'h0640)
    else $error("third LED word low bits wrong after reset");
  a_blink_reset_word: assert property ($fell(rst) |-> blink_cfg_q == 7'h06)
    else $error("blink word wrong after reset");
  a_strap_source_load: assert property (strap_pending_q |=>
                                        second_cfg_q[15:14] == mode_to_source($past(strap_sync_q))
                                        && third_cfg_q[15:14] == second_cfg_q[15:14])
    else $error("source field not taken from strap");
  a_src_field_write: assert property (req && wb_we_i && idx == `THIRD_CFG_IDX && wb_sel_i[1]
                                      |=> third_cfg_q[15:14] == $past(wb_dat_i[15:14]))
    else $error("third LED source field write lost");
  a_duty_field_write: assert property (req && wb_we_i && idx == `BLINK_CFG_IDX && wb_sel_i[0]
                                       |=> blink_cfg_q == $past(wb_dat_i[6:0]))
    else $error("blink word write lost");
  a_and_source_dark: assert property (second_cfg_q[15:14] == 2'h2 && !serial_link_up
                                      |=> !second_led)
    else $error("AND source lit LED with serial link down");
  a_ack_single_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // ****************************************
  // bus answer checks
  // ****************************************
  // one answer per taken request and never one unasked, so a master cannot lose a cycle
  a_ack_after_take: assert property (req
                                     |=> wb_ack_o)
    else $error("taken request got no ack");

  a_ack_unasked: assert property (!req
                                  |=> !wb_ack_o)
    else $error("ack without a taken request");

  // read data stand while ack is up; the upper half always reads zero
  a_read_data_held: assert property (wb_ack_o && !$past(wb_we_i)
                                     |-> wb_dat_o == {16'h0000, $past(rd_word)})
    else $error("read data not the addressed word");

  a_blink_reserved_zero: assert property (req && !wb_we_i && idx == `BLINK_CFG_IDX
                                          |=> wb_dat_o[15:7] == 9'h000)
    else $error("reserved blink bits read nonzero");

  // a stray write must leave every word alone
  a_stray_write_lost: assert property (req && wb_we_i && idx != `SECOND_CFG_IDX
                                       && idx != `THIRD_CFG_IDX && idx != `BLINK_CFG_IDX
                                       |=> $stable(second_cfg_q) && $stable(third_cfg_q) && $stable(blink_cfg_q))
    else $error("write to unmapped index changed a word");

  // ****************************************
  // source selection checks
  // ****************************************
  a_serial_source_dark: assert property (second_cfg_q[`F_SRC_HI:`F_SRC_LO] == 2'h1 && !serial_link_up
                                         |=> !second_led)
    else $error("serial source lit LED with serial link down");

  a_copper_source_dark: assert property (third_cfg_q[`F_SRC_HI:`F_SRC_LO] == 2'h0 && !copper_link_up
                                         |=> !third_led)
    else $error("copper source lit LED with copper link down");

  // with a steady bit only, the merged status of either side must light the LED
  a_or_source_lit: assert property (third_cfg_q[`F_SRC_HI:`F_SRC_LO] == 2'h3
                                    && third_cfg_q[13:0] == 14'h0020
                                    && third_st[`ST_LINK] && third_st[`ST_100]
                                    |=> third_led)
    else $error("OR source left LED dark");
endmodule

/* File: test/led_board_model.sv */
// Purpose: board LEDs watched by an observer that counts lit cycles
// Assumes: LEDs are lit when driven high
// Notes:   a window restarts on each rise of meas_en; counts hold after it
`timescale 1ns/1ps
module led_board_model (
  input  wire logic        core_clk,
  input  wire logic        second_led,
  input  wire logic        third_led,
  input  wire logic        meas_en,
  output logic      [31:0] second_lit,
  output logic      [31:0] third_lit
);
  logic meas_q;
  always_ff @(posedge core_clk) begin
    meas_q <= meas_en;
  end
  // a plain integrator: it cannot tell a glitch from a blink, so windows span whole periods
  always_ff @(posedge core_clk) begin
    if (meas_en && !meas_q) begin
      second_lit <= {31'h0, second_led};
      third_lit  <= {31'h0, third_led};
    end else if (meas_en) begin
      second_lit <= second_lit + {31'h0, second_led};
      third_lit  <= third_lit + {31'h0, third_led};
    end
  end
endmodule

/* File: test/test_led_indicator_control.sv */
// Purpose: register and LED checks of the LED block
// Assumes: slot of 2 cycles and minimum-on of 8 cycles
// Notes:   lit counts taken over whole blink periods, so phase does not matter
`timescale 1ns/1ps
`include "led_indicator_control_map.svh"
module test_led_indicator_control import led_indicator_control_pkg::*;;
  localparam int SLOT = 2;
  localparam int MINON = 8;
  localparam logic [17:0] A2 = {`SECOND_CFG_IDX, 2'b00};
  localparam logic [17:0] A3 = {`THIRD_CFG_IDX, 2'b00};
  localparam logic [17:0] AB = {`BLINK_CFG_IDX, 2'b00};
  localparam logic [17:0] AU = 18'h28040;
  logic        core_clk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [17:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, second_lit, third_lit, rd;
  logic [3:0]  wb_sel_i;
  logic [1:0]  strap_chip_mode, copper_speed, serial_speed;
  logic        copper_link_up, copper_full_duplex, copper_tx_act, copper_rx_act;
  logic        serial_link_up, serial_full_duplex, serial_tx_act, serial_rx_act;
  logic        second_led, third_led, meas_en, copper_collision;
  int          n_fail, total_checks, len;
  int          ons[8] = '{6, 8, 9, 10, 6, 4, 3, 2};
  int          src_on[4] = '{1, 0, 0, 1};
  led_indicator_control #(.SLOT_CYC(SLOT), .MIN_ON_CYC(MINON)) DUT (
    .core_clk(core_clk), .rst(rst),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .strap_chip_mode(strap_chip_mode),
    .copper_link_up(copper_link_up), .copper_speed(copper_speed),
    .copper_full_duplex(copper_full_duplex), .copper_tx_act(copper_tx_act),
    .copper_rx_act(copper_rx_act), .copper_collision(copper_collision),
    .serial_link_up(serial_link_up), .serial_speed(serial_speed),
    .serial_full_duplex(serial_full_duplex), .serial_tx_act(serial_tx_act),
    .serial_rx_act(serial_rx_act), .serial_collision(1'b0),
    .second_led(second_led), .third_led(third_led)
  );
  led_board_model board (
    .core_clk(core_clk), .second_led(second_led), .third_led(third_led),
    .meas_en(meas_en), .second_lit(second_lit), .third_lit(third_lit)
  );
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // ********************
  // bus, status and compare tasks
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_lit(input logic [31:0] e2, input logic [31:0] e3);
    chk(second_lit, e2);
    chk(third_lit, e3);
  endtask
  task automatic chk_range(input logic [31:0] got, input int lo, input int hi);
    total_checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t lit count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // ack may come late; only the bound cuts the wait short
  task automatic wb(input logic [17:0] a, input logic we, input logic [15:0] d, input logic [3:0] s);
    int n;
    @(posedge core_clk);
    wb_adr_i <= a;
    wb_we_i  <= we;
    wb_dat_i <= {16'h0, d};
    wb_sel_i <= s;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      $display("[FAIL] %0t no bus answer", $time);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 16'h0, 4'h3);
    chk(rd, exp);
  endtask
  task automatic set_st(input logic cl, input logic [1:0] spd, input logic fd, input logic [1:0] act);
    @(posedge core_clk);
    copper_link_up     <= cl;
    serial_link_up     <= 1'b0;
    copper_speed       <= spd;
    serial_speed       <= spd;
    copper_full_duplex <= fd;
    serial_full_duplex <= fd;
    {copper_rx_act, copper_tx_act} <= act;
    {serial_rx_act, serial_tx_act} <= act;
  endtask
  task automatic measure(input int n);
    @(posedge core_clk);
    meas_en <= 1'b1;
    repeat (n) @(posedge core_clk);
    meas_en <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic do_reset(input logic [1:0] s);
    @(posedge core_clk);
    rst <= 1'b1;
    strap_chip_mode <= s;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ********************
  // watchdog and main sequence
  // ********************
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report;
  end
  initial begin
    {rst, wb_we_i, wb_cyc_i, wb_stb_i, meas_en} = 5'h10;
    {wb_adr_i, wb_dat_i, wb_sel_i, strap_chip_mode} = '0;
    {copper_link_up, copper_speed, copper_full_duplex, copper_tx_act, copper_rx_act} = '0;
    {serial_link_up, serial_speed, serial_full_duplex, serial_tx_act, serial_rx_act} = '0;
    n_fail = 0;
    total_checks = 0;
    copper_collision = 1'b0;
    do_reset(2'h2);
    rd_chk(A2, {16'h0, 2'b10, 14'h0620});
    rd_chk(A3, {16'h0, 2'b10, 14'h0640});
    rd_chk(AB, 32'h0000_0006);
    do_reset(2'h0);
    rd_chk(A2, {16'h0, `SECOND_CFG_RST});
    wb(AU, 1'b1, 16'hFFFF, 4'h3);
    rd_chk(AU, 32'h0000_0000);
    wb(AB, 1'b1, 16'hFFFF, 4'h3);
    rd_chk(AB, 32'h0000_007F);
    wb(A2, 1'b1, 16'hFFFF, 4'h1);
    rd_chk(A2, 32'h0000_06FF);
    wb(AB, 1'b1, 16'h0006, 4'h3);
    wb(A2, 1'b1, 16'h0620, 4'h3);
    set_st(1'b1, `SPEED_100, 1'b0, 2'b00);
    measure(20);
    chk_lit(20, 0);
    set_st(1'b1, `SPEED_1000, 1'b0, 2'b00);
    measure(20);
    chk_lit(0, 20);
    set_st(1'b0, `SPEED_1000, 1'b0, 2'b00);
    measure(20);
    chk_lit(0, 0);
    // only copper is up: copper and OR light, serial and AND stay dark
    set_st(1'b1, `SPEED_100, 1'b0, 2'b00);
    for (int i = 0; i < 4; i++) begin
      wb(A2, 1'b1, {i[1:0], 14'h0020}, 4'h3);
      wb(A3, 1'b1, {i[1:0], 14'h0020}, 4'h3);
      measure(10);
      chk_lit(src_on[i] * 10, src_on[i] * 10);
    end
    wb(A2, 1'b1, 16'h1000, 4'h3);
    set_st(1'b1, `SPEED_100, 1'b1, 2'b00);
    measure(10);
    chk_lit(10, 10);
    set_st(1'b1, `SPEED_100, 1'b0, 2'b00);
    measure(10);
    chk_lit(0, 10);
    wb(A2, 1'b1, 16'h0640, 4'h3);
    wb(A3, 1'b1, 16'h0640, 4'h3);
    set_st(1'b1, `SPEED_1000, 1'b0, 2'b01);
    for (int d = 0; d < 8; d++) begin
      wb(AB, 1'b1, {9'h0, d[2:0], 4'hC}, 4'h3);
      repeat (24) @(posedge core_clk);
      measure(48);
      chk_lit(ons[d] * 4, ons[d] * 4);
    end
    set_st(1'b1, `SPEED_1000, 1'b0, 2'b10);
    for (int r = 0; r < 4; r++) begin
      wb(AB, 1'b1, {12'h0, r[1:0], 2'b00}, 4'h3);
      len = (8 >> r) * SLOT;
      repeat (12 * len) @(posedge core_clk);
      measure(12 * len);
      chk_lit(6 * len, 6 * len);
    end
    // speed blink must win over the steady bit set beside it
    wb(A2, 1'b1, 16'h0022, 4'h3);
    wb(A3, 1'b1, 16'h0022, 4'h3);
    set_st(1'b1, `SPEED_100, 1'b0, 2'b00);
    for (int r = 0; r < 4; r++) begin
      wb(AB, 1'b1, {14'h0, r[1:0]}, 4'h3);
      len = (8 >> r) * SLOT;
      repeat (12 * len) @(posedge core_clk);
      measure(12 * len);
      chk_lit(6 * len, 6 * len);
    end
    wb(A2, 1'b1, 16'h0100, 4'h3);
    wb(A3, 1'b1, 16'h0080, 4'h3);
    set_st(1'b1, `SPEED_100, 1'b0, 2'b11);
    set_st(1'b1, `SPEED_100, 1'b0, 2'b00);
    measure(40);
    chk_range(second_lit, MINON - 2, MINON + 2);
    chk_range(third_lit, MINON - 2, MINON + 2);
    // collision blinks at the first rate, counted over one whole 16 Hz period
    wb(A2, 1'b1, 16'h0008, 4'h3);
    wb(AB, 1'b1, 16'h0003, 4'h3);
    copper_collision <= 1'b1;
    repeat (24) @(posedge core_clk);
    measure(12 * SLOT);
    chk_lit(6 * SLOT, 0);
    final_report;
  end
endmodule
